// ==== core/switch_address_decode_output_offset.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - four 16-bit read/write advance registers at 0x00A..0x00D, reset zero.
// - one two-bit field per output stream, eight per register, low first.
// - codes 0..3 advance output bit 0 by 0, 15, 30, 45 ns.
// - advance acts only in 8, 16, 4/8, 16/8 modes; else software zeroes (the logic here forces the code to zero itself).
// - data memory read needs two cycles; second returns correct content.
// - top address line low selects registers by the lower thirteen lines.
// - top address line high selects data or connection memory by select bits.
// - stream from A12..A8, channel from A7..A0 on memory accesses.
// - data memory reads address a serial input stream and channel.
// - connection memory writes address a serial output stream and channel.
module switch_address_decode_output_offset
  import adv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [adv_pkg::ADDR_W-1:0] host_addr,
  input wire logic [adv_pkg::DATA_W-1:0] host_wdata,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] memory_select_bits,
  input wire logic [2:0] rate_mode,
  input wire logic [adv_pkg::DATA_W-1:0] mem_rdata,
  output logic [adv_pkg::DATA_W-1:0] host_data_lines,
  output logic reg_sel,
  output logic [adv_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic dm_rd,
  output logic cm_wr,
  output logic cm_rd,
  output logic [adv_pkg::STREAM_W-1:0] in_stream,
  output logic [adv_pkg::CHAN_W-1:0] in_chan,
  output logic [adv_pkg::STREAM_W-1:0] serial_output_stream,
  output logic [adv_pkg::CHAN_W-1:0] out_chan,
  output logic [2*adv_pkg::STREAMS-1:0] stream_output_advance_field,
  output logic [8*adv_pkg::STREAMS-1:0] stream_advance_ns
);
  import adv_pkg::*;

  logic [DATA_W-1:0] adv_r [ADV_REGS];
  logic [DATA_W-1:0] adv_nxt [ADV_REGS];
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  rd_state_t rd_r, rd_nxt;
  logic [ADDR_W-1:0] last_addr_r, last_addr_nxt;
  logic region_select_address_line;
  logic is_mem, dm_sel, cm_sel;
  logic [1:0] adv_idx;
  logic adv_hit;

  // address split into region, register and memory coordinates
  always_comb
  begin
    region_select_address_line = host_addr[REGION_BIT];
    is_mem = host_cs && region_select_address_line;
    reg_sel = host_cs && !region_select_address_line;
    reg_addr = host_addr[REG_ADDR_W-1:0];
    dm_sel = is_mem && (memory_select_bits == MEM_SEL_DATA);
    cm_sel = is_mem && (memory_select_bits == MEM_SEL_CONN);
    dm_rd = dm_sel && host_rd;
    cm_wr = cm_sel && host_wr;
    cm_rd = cm_sel && host_rd;
    in_stream = host_addr[STREAM_HI:STREAM_LO];
    in_chan = host_addr[CHAN_HI:CHAN_LO];
    serial_output_stream = host_addr[STREAM_HI:STREAM_LO];
    out_chan = host_addr[CHAN_HI:CHAN_LO];
  end

  // advance register decode, register chain
  always_comb
  begin
    adv_hit = 1'b0;
    adv_idx = 2'h0;
    if (reg_addr == OFS_ADV_0_7)
    begin
      adv_hit = 1'b1;
      adv_idx = 2'h0;
    end
    else if (reg_addr == OFS_ADV_8_15)
    begin
      adv_hit = 1'b1;
      adv_idx = 2'h1;
    end
    else if (reg_addr == OFS_ADV_16_23)
    begin
      adv_hit = 1'b1;
      adv_idx = 2'h2;
    end
    else if (reg_addr == OFS_ADV_24_31)
    begin
      adv_hit = 1'b1;
      adv_idx = 2'h3;
    end
  end

  // register writes and read data, with two-cycle data memory read
  always_comb
  begin
    for (int i = 0; i < ADV_REGS; i++)
      adv_nxt[i] = adv_r[i];
    rdata_nxt = rdata_r;
    rd_nxt = rd_r;
    last_addr_nxt = last_addr_r;
    if (reg_sel && adv_hit && host_wr)
      adv_nxt[adv_idx] = host_wdata;
    if (reg_sel && host_rd)
      rdata_nxt = adv_hit ? adv_r[adv_idx] : 16'h0000;
    else if (cm_rd)
      rdata_nxt = mem_rdata;
    else if (dm_rd)
    begin
      // first cycle primes the fetch; only a repeat read returns data
      if (rd_r == RD_PRIMED && last_addr_r == host_addr)
        rdata_nxt = mem_rdata;
      else
        rdata_nxt = 16'h0000;
      rd_nxt = RD_PRIMED;
      last_addr_nxt = host_addr;
    end
    // any other selected access breaks a pending read pair
    if (!dm_rd && host_cs && (host_wr || host_rd))
      rd_nxt = RD_IDLE;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < ADV_REGS; i++)
        adv_r[i] <= ADV_RESET;
      rdata_r <= 16'h0000;
      rd_r <= RD_IDLE;
      last_addr_r <= 14'h0000;
    end
    else
    begin
      for (int i = 0; i < ADV_REGS; i++)
        adv_r[i] <= adv_nxt[i];
      rdata_r <= rdata_nxt;
      rd_r <= rd_nxt;
      last_addr_r <= last_addr_nxt;
    end
  end

  assign host_data_lines = rdata_r;

  // per-stream field extraction and advance application
  genvar s;
  generate
    for (s = 0; s < STREAMS; s++)
    begin : g_stream
      adv_field_apply u_apply (
        .code(adv_r[s/FIELDS_PER_REG][2*(s%FIELDS_PER_REG) +: 2]),
        .rate_mode(rate_mode),
        .eff_code(stream_output_advance_field[2*s +: 2]),
        .adv_ns(stream_advance_ns[8*s +: 8])
      );
    end
  endgenerate

  // assertions
  // data memory read repeated at the same address
  sequence s_dm_read_twice;
    dm_rd ##1 dm_rd && $stable(host_addr);
  endsequence

  // advance register write, then a read of it in the next cycle
  sequence s_adv_write;
    reg_sel && adv_hit && host_wr;
  endsequence

  sequence s_adv_read_same;
    reg_sel && host_rd && !host_wr && $stable(reg_addr);
  endsequence

  a_adv_reset_zero: assert property (@(posedge clk)
    $rose(rstn) |-> adv_r[0] == ADV_RESET && adv_r[1] == ADV_RESET &&
    adv_r[2] == ADV_RESET && adv_r[3] == ADV_RESET)
    else $error("advance register not zero after reset");

  a_adv_write_read: assert property (@(posedge clk)
    disable iff (!rstn)
    s_adv_write ##1 s_adv_read_same |=>
    host_data_lines == $past(host_wdata, 2))
    else $error("advance register readback mismatch");

  a_adv_hold: assert property (@(posedge clk)
    disable iff (!rstn)
    !(reg_sel && adv_hit && host_wr) |=> $stable(adv_r[0]) &&
    $stable(adv_r[1]) && $stable(adv_r[2]) && $stable(adv_r[3]))
    else $error("advance register changed without a write");

  a_dm_second_read: assert property (@(posedge clk)
    disable iff (!rstn)
    s_dm_read_twice |=> host_data_lines == $past(mem_rdata))
    else $error("second data memory read lost data");

  a_dm_first_read: assert property (@(posedge clk)
    disable iff (!rstn)
    dm_rd && rd_r == RD_IDLE |=> host_data_lines == 16'h0000)
    else $error("first data memory read returned data");

  a_region_reg: assert property (@(posedge clk)
    disable iff (!rstn)
    host_cs && !host_addr[13] |-> reg_sel && !dm_rd && !cm_wr)
    else $error("register region misdecoded");

  a_unmapped_zero: assert property (@(posedge clk)
    disable iff (!rstn)
    reg_sel && host_rd && !host_wr && !adv_hit |=>
    host_data_lines == 16'h0000)
    else $error("unmapped register read not zero");

  a_region_mem: assert property (@(posedge clk)
    disable iff (!rstn)
    host_cs && host_addr[13] && host_wr && memory_select_bits == 2'h1
    |-> cm_wr && !reg_sel)
    else $error("connection memory write misrouted");

  a_dm_route: assert property (@(posedge clk)
    disable iff (!rstn)
    host_cs && host_addr[13] && host_rd &&
    memory_select_bits == MEM_SEL_DATA |-> dm_rd && !cm_rd && !reg_sel)
    else $error("data memory read misrouted");

  a_stream_chan: assert property (@(posedge clk)
    disable iff (!rstn)
    cm_wr |-> serial_output_stream == host_addr[12:8] &&
    out_chan == host_addr[7:0])
    else $error("stream or channel misdecoded");

  a_field_pack: assert property (@(posedge clk)
    disable iff (!rstn)
    rate_mode == 3'h2 |-> stream_output_advance_field[63:62] ==
    adv_r[3][15:14] && stream_output_advance_field[1:0] == adv_r[0][1:0])
    else $error("field packing wrong");

  a_slow_no_adv: assert property (@(posedge clk)
    disable iff (!rstn)
    rate_mode == 3'h0 |-> stream_output_advance_field == '0)
    else $error("advance applied in slow mode");

  a_slow_no_ns: assert property (@(posedge clk)
    disable iff (!rstn)
    rate_mode == RATE_4M |-> stream_advance_ns == '0)
    else $error("advance time given in slow mode");

  a_adv_ns: assert property (@(posedge clk)
    disable iff (!rstn)
    rate_mode == 3'h3 && adv_r[0][1:0] == 2'h3 |->
    stream_advance_ns[7:0] == 8'h2d)
    else $error("advance time wrong");
endmodule

// ==== core/adv_pkg.sv ====
package adv_pkg;
  // host bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 13;
  localparam int STREAM_W = 5;
  localparam int CHAN_W = 8;
  localparam int FIELD_W = 2;
  localparam int STREAMS = 32;
  localparam int ADV_REGS = 4;
  localparam int FIELDS_PER_REG = 8;
  // address fields
  localparam int REGION_BIT = 13;
  localparam int STREAM_HI = 12;
  localparam int STREAM_LO = 8;
  localparam int CHAN_HI = 7;
  localparam int CHAN_LO = 0;
  // register offsets
  localparam logic [12:0] OFS_ADV_0_7 = 13'h000a;
  localparam logic [12:0] OFS_ADV_8_15 = 13'h000b;
  localparam logic [12:0] OFS_ADV_16_23 = 13'h000c;
  localparam logic [12:0] OFS_ADV_24_31 = 13'h000d;
  localparam logic [15:0] ADV_RESET = 16'h0000;
  // memory select codes
  localparam logic [1:0] MEM_SEL_DATA = 2'h0;
  localparam logic [1:0] MEM_SEL_CONN = 2'h1;
  // advance timing: 15 ns per code step
  localparam int ADV_STEP_NS = 15;
  localparam int CLK_PERIOD_NS = 10;
  // rate modes; only 8M, 16M, 4/8M and 16/8M allow an output advance
  localparam logic [2:0] RATE_2M = 3'h0;
  localparam logic [2:0] RATE_4M = 3'h1;
  localparam logic [2:0] RATE_8M = 3'h2;
  localparam logic [2:0] RATE_16M = 3'h3;
  localparam logic [2:0] RATE_2_4M = 3'h4;
  localparam logic [2:0] RATE_4_8M = 3'h5;
  localparam logic [2:0] RATE_16_8M = 3'h6;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_PRIMED = 2'b01
  } rd_state_t;
endpackage

// ==== core/adv_field_apply.sv ====
`timescale 1ns/100ps
// gates one stream's advance code by the rate mode
module adv_field_apply
  import adv_pkg::*;
(
  input wire logic [1:0] code,
  input wire logic [2:0] rate_mode,
  output logic [1:0] eff_code,
  output logic [7:0] adv_ns
);
  logic allowed;
  // advance only in the faster and mixed fast modes
  always_comb
  begin
    allowed = (rate_mode == RATE_8M) || (rate_mode == RATE_16M) ||
      (rate_mode == RATE_4_8M) || (rate_mode == RATE_16_8M);
    eff_code = allowed ? code : 2'h0;
    adv_ns = 8'(ADV_STEP_NS) * {6'h00, eff_code};
  end
endmodule

// ==== sim/mem_model.sv ====
`timescale 1ns/100ps
// far-side memory: answers with a word built from stream and channel
module mem_model
(
  input wire logic [4:0] in_stream,
  input wire logic [7:0] in_chan,
  input wire logic dm_rd,
  input wire logic cm_rd,
  output logic [15:0] mem_rdata
);
  logic [15:0] word;
  // lines show the inverse pattern while no read is asked for
  assign word = {in_stream, 3'h5, in_chan};
  assign mem_rdata = (dm_rd || cm_rd) ? word : ~word;
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb;
  import adv_pkg::*;
  logic clk = 0, rstn = 0, cs = 0, wr = 0, rd = 0;
  logic [13:0] a = 0;
  logic [15:0] wd = 0;
  logic [1:0] ms = 0;
  logic [2:0] rm = 0;
  logic [15:0] mrd, q;
  logic rs, dmr, cmw, cmr;
  logic [12:0] ra;
  logic [4:0] ist, ost;
  logic [7:0] ich, och;
  logic [63:0] fld;
  logic [255:0] ns;
  logic [63:0] exp_fld;
  logic [15:0] v [4] = '{16'he4e4, 16'h1b1b, 16'h5a5a, 16'hffff};
  int bad_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  switch_address_decode_output_offset u_dut (.clk(clk), .rstn(rstn),
    .host_addr(a), .host_wdata(wd), .host_cs(cs), .host_wr(wr),
    .host_rd(rd), .memory_select_bits(ms), .rate_mode(rm),
    .mem_rdata(mrd), .host_data_lines(q), .reg_sel(rs), .reg_addr(ra),
    .dm_rd(dmr), .cm_wr(cmw), .cm_rd(cmr), .in_stream(ist),
    .in_chan(ich), .serial_output_stream(ost), .out_chan(och),
    .stream_output_advance_field(fld), .stream_advance_ns(ns));
  mem_model u_mem (.in_stream(ist), .in_chan(ich), .dm_rd(dmr),
    .cm_rd(cmr), .mem_rdata(mrd));
  // one compare for every kind of value, zero-extended
  task chk(input logic [255:0] g, input logic [255:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // one host cycle, request held over one rising edge
  task acc(input logic [13:0] ad, input logic w, input logic [15:0] d);
    @(negedge clk);
    a = ad;
    wd = d;
    cs = 1;
    wr = w;
    rd = !w;
    @(negedge clk);
    cs = 0;
    wr = 0;
    rd = 0;
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial
  begin
    #100000;
    bad_count++;
    print_verdict;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rstn = 1;
    ms = MEM_SEL_DATA;
    // reset values, then writes one idle cycle apart and read-back
    for (int i = 0; i < 4; i++)
    begin
      acc(14'h000a + 14'(i), 0, 16'h0000);
      chk(q, 16'h0000);
    end
    for (int i = 0; i < 4; i++)
      acc(14'h000a + 14'(i), 1, v[i]);
    acc(14'h000e, 1, 16'h1234);
    for (int i = 0; i < 4; i++)
    begin
      acc(14'h000a + 14'(i), 0, 16'h0000);
      chk(q, v[i]);
    end
    // unmapped register read decodes as register region
    @(negedge clk);
    a = 14'h0009;
    cs = 1;
    rd = 1;
    #1 chk(rs, 1'b1);
    chk(ra, 13'h0009);
    @(negedge clk);
    cs = 0;
    rd = 0;
    chk(q, 16'h0000);
    acc(14'h000d, 0, 16'h0000);
    chk(q, v[3]);
    acc(14'h000e, 0, 16'h0000);
    chk(q, 16'h0000);
    // advance fields gated by every rate mode
    for (int r = 0; r < 7; r++)
    begin
      @(negedge clk);
      rm = 3'(r);
      exp_fld = (r inside {2, 3, 5, 6}) ? {v[3], v[2], v[1], v[0]} : 64'h0;
      #1 chk(fld, exp_fld);
    end
    @(negedge clk);
    rm = RATE_8M;
    #1 chk(ns[31:0], {8'h2d, 8'h1e, 8'h0f, 8'h00});
    // connection memory read comes back the next cycle
    @(negedge clk);
    a = 14'h2103;
    ms = MEM_SEL_CONN;
    cs = 1;
    rd = 1;
    #1 chk({rs, dmr, cmw, cmr}, 4'h1);
    @(negedge clk);
    cs = 0;
    rd = 0;
    chk(q, {5'h01, 3'h5, 8'h03});
    // data memory read twice at one address
    @(negedge clk);
    a = 14'h335a;
    ms = MEM_SEL_DATA;
    cs = 1;
    rd = 1;
    #1 chk({rs, dmr, cmw, cmr}, 4'h4);
    chk({ist, ich}, {5'h13, 8'h5a});
    @(negedge clk);
    chk(q, 16'h0000);
    @(negedge clk);
    cs = 0;
    rd = 0;
    chk(q, {5'h13, 3'h5, 8'h5a});
    // connection memory write to an output stream
    @(negedge clk);
    a = 14'h3e07;
    ms = MEM_SEL_CONN;
    cs = 1;
    wr = 1;
    #1 chk({rs, dmr, cmw, cmr}, 4'h2);
    chk({ost, och}, {5'h1e, 8'h07});
    @(negedge clk);
    cs = 0;
    wr = 0;
    // write then read of one register in back-to-back cycles
    @(negedge clk);
    a = 14'h000b;
    wd = 16'h0c3c;
    cs = 1;
    wr = 1;
    @(negedge clk);
    wr = 0;
    rd = 1;
    @(negedge clk);
    cs = 0;
    rd = 0;
    chk(q, 16'h0c3c);
    // reset in mid-run clears the written register
    rstn = 0;
    @(negedge clk);
    rstn = 1;
    acc(14'h000b, 0, 16'h0000);
    chk(q, 16'h0000);
    print_verdict;
  end
endmodule
